// >>> rtl/sfpc_pause_ctrl.sv
// Serial interface pause control of a serial flash device.
// Assumes an SPI host in mode 0 or 3 drives select, clock, input and pause.
`timescale 1ns/1ps
`include "sfpc_params.svh"
`default_nettype none

module sfpc_pause_ctrl #(
  parameter int OP_CYCLES = `SFPC_OP_CYC
) (
  // System clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_nrst,
  // Serial pins
  input  wire logic       i_sck,
  input  wire logic       i_cs_n,
  input  wire logic       i_hold_n,
  input  wire logic       i_si,
  input  wire logic       i_wp_n,
  output logic            o_so,
  output logic            o_so_oe,
  // Command side
  output logic [7:0]      o_rx_data,
  output logic            o_rx_valid,
  input  wire logic       i_tx_load,
  input  wire logic [7:0] i_tx_data,
  input  wire logic       i_write_latch_set,
  output logic            o_write_latch_flag,
  output logic            o_cmd_abort,
  output logic            o_write_guard,
  // Internal operation
  input  wire logic       i_op_start,
  output logic            o_op_busy,
  output logic            o_paused
);

  if (OP_CYCLES < 1 || OP_CYCLES > 65535) begin : g_chk
    $error("OP_CYCLES must lie in 1..65535");
  end

  localparam logic [15:0] OP_LOAD = 16'(OP_CYCLES - 1);

  sfpc_pkg::sfpc_link_t link_r;
  sfpc_pkg::sfpc_link_t link_nxt;
  sfpc_pkg::sfpc_neg_t  neg_r;
  sfpc_pkg::sfpc_neg_t  neg_nxt;
  sfpc_pkg::sfpc_sys_t  sys_r;
  sfpc_pkg::sfpc_sys_t  sys_nxt;

  logic       link_arst_n;
  logic       rx_tgl_r;
  logic       byte_done;
  logic       paused;
  logic [3:0] sy_q;
  logic       cs_s;
  logic       hold_s;
  logic       wp_s;
  logic       tgl_s;
  logic       abort_cond;

  // Select release resets the link side, so a new frame starts at bit zero
  assign link_arst_n = i_nrst & ~i_cs_n;

  // Paused level: in the high phase the falling-edge capture holds,
  // in the low phase the pin acts at once
  assign paused = ~i_cs_n & (i_sck ? neg_r.pause_fall : ~i_hold_n);
  assign o_paused = paused;

  // Rising edge: sample input unless the pin asks for a pause at this edge
  always_comb begin
    link_nxt  = link_r;
    byte_done = 1'b0;
    if (i_hold_n) begin
      link_nxt.rx_sh   = {link_r.rx_sh[6:0], i_si};
      link_nxt.bit_cnt = link_r.bit_cnt + 3'h1;
      if (link_r.bit_cnt == `SFPC_LAST_BIT) begin
        byte_done        = 1'b1;
        link_nxt.rx_byte = {link_r.rx_sh[6:0], i_si};
        // Transmit word is quasi-static; load it between bytes only
        link_nxt.tx_word = sys_r.tx_hold;
      end
    end
  end

  always_ff @(posedge i_sck or negedge link_arst_n) begin
    if (!link_arst_n) begin
      link_r <= '0;
    end else begin
      link_r <= link_nxt;
    end
  end

  // Byte event toggles across to the system clock; survives select release
  always_ff @(posedge i_sck or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_tgl_r <= 1'b0;
    end else begin
      rx_tgl_r <= rx_tgl_r ^ byte_done;
    end
  end

  // Falling edge opens each low phase: latch the pause and shift output
  always_comb begin
    neg_nxt            = neg_r;
    neg_nxt.pause_fall = ~i_hold_n;
    if (i_hold_n) begin
      neg_nxt.so_bit = link_r.tx_word[~link_r.bit_cnt];
    end
  end

  always_ff @(negedge i_sck or negedge link_arst_n) begin
    if (!link_arst_n) begin
      neg_r <= '{pause_fall: 1'b0, so_bit: `SFPC_SO_RST};
    end else begin
      neg_r <= neg_nxt;
    end
  end

  assign o_so    = neg_r.so_bit;
  assign o_so_oe = ~i_cs_n & ~paused;

  // Pins into the system clock
  sfpc_sync #(
    .W   (4),
    .RST (`SFPC_SYNC_RST)
  ) u_sync (
    .i_clk  (i_sys_clk),
    .i_nrst (i_nrst),
    .i_d    ({rx_tgl_r, i_cs_n, i_hold_n, i_wp_n}),
    .o_q    (sy_q)
  );

  assign wp_s   = sy_q[`SFPC_SY_WP];
  assign hold_s = sy_q[`SFPC_SY_HOLD];
  assign cs_s   = sy_q[`SFPC_SY_CS];
  assign tgl_s  = sy_q[`SFPC_SY_TGL];

  // Select seen rising while the pause pin still holds
  assign abort_cond = cs_s & ~sys_r.cs_n_d & ~hold_s;

  always_comb begin
    sys_nxt          = sys_r;
    sys_nxt.cs_n_d   = cs_s;
    sys_nxt.abort    = abort_cond;
    sys_nxt.guard    = ~wp_s;
    sys_nxt.tgl_seen = tgl_s;
    sys_nxt.rx_valid = tgl_s ^ sys_r.tgl_seen;
    if (tgl_s ^ sys_r.tgl_seen) begin
      sys_nxt.rx_data = link_r.rx_byte;
    end
    if (i_tx_load) begin
      sys_nxt.tx_hold = i_tx_data;
    end
    // A set in the same cycle as the abort wins, so no set is lost
    if (i_write_latch_set) begin
      sys_nxt.wlf = 1'b1;
    end else if (abort_cond) begin
      sys_nxt.wlf = 1'b0;
    end
    // The internal operation never looks at the pause pin
    unique case (sys_r.op)
      sfpc_pkg::SFPC_OP_IDLE: begin
        if (i_op_start) begin
          sys_nxt.op     = sfpc_pkg::SFPC_OP_RUN;
          sys_nxt.op_cnt = OP_LOAD;
        end
      end
      sfpc_pkg::SFPC_OP_RUN: begin
        if (sys_r.op_cnt == 16'h0) begin
          sys_nxt.op = sfpc_pkg::SFPC_OP_IDLE;
        end else begin
          sys_nxt.op_cnt = sys_r.op_cnt - 16'h1;
        end
      end
      default: begin
        sys_nxt.op = sfpc_pkg::SFPC_OP_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sys_r <= '{op: sfpc_pkg::SFPC_OP_IDLE, op_cnt: 16'h0, wlf: `SFPC_WLF_RST,
                 abort: 1'b0, guard: 1'b0, cs_n_d: 1'b1, tgl_seen: 1'b0,
                 rx_data: 8'h0, rx_valid: 1'b0, tx_hold: 8'h0};
    end else begin
      sys_r <= sys_nxt;
    end
  end

  assign o_write_latch_flag = sys_r.wlf;
  assign o_cmd_abort        = sys_r.abort;
  assign o_write_guard      = sys_r.guard;
  assign o_rx_data          = sys_r.rx_data;
  assign o_rx_valid         = sys_r.rx_valid;
  assign o_op_busy          = (sys_r.op == sfpc_pkg::SFPC_OP_RUN);

  // Checks on the link side
  AST_SO_FLOAT: assert property (@(posedge i_sck) disable iff (!i_nrst)
    (!i_cs_n && !i_hold_n) |-> !o_so_oe)
    else $error("serial output driven while paused");

  AST_SHIFT_FROZEN: assert property (@(posedge i_sck)
    disable iff (!link_arst_n)
    (!i_hold_n) |=> $stable(link_r.rx_sh) && $stable(link_r.bit_cnt))
    else $error("shift state moved during a pause");

  AST_SHIFT_RUNS: assert property (@(posedge i_sck)
    disable iff (!link_arst_n)
    (i_hold_n) |=> link_r.bit_cnt == $past(link_r.bit_cnt) + 3'h1)
    else $error("bit counter missed an edge outside a pause");

  AST_NO_PAUSE_DESELECTED: assert property (@(posedge i_sys_clk)
    disable iff (!i_nrst) i_cs_n |-> !paused && !o_so_oe)
    else $error("paused without chip select");

  AST_HIGH_PHASE_HOLDS: assert property (@(posedge i_sys_clk)
    disable iff (!i_nrst)
    (i_sck && !i_cs_n) |-> (paused == neg_r.pause_fall))
    else $error("pause changed inside a clock high phase");

  AST_LOW_PHASE_ENTRY: assert property (@(posedge i_sys_clk)
    disable iff (!i_nrst)
    (!i_sck && !i_cs_n && !i_hold_n) |-> paused)
    else $error("pause not entered during clock low");

  // Checks on the system side
  AST_ABORT_PULSE: assert property (@(posedge i_sys_clk)
    disable iff (!i_nrst)
    (cs_s && !sys_r.cs_n_d && !hold_s) |=> o_cmd_abort ##1 !o_cmd_abort)
    else $error("abort pulse missing or stretched");

  AST_WLF_CLEAR: assert property (@(posedge i_sys_clk)
    disable iff (!i_nrst)
    (abort_cond && !i_write_latch_set) |=> !o_write_latch_flag)
    else $error("write latch flag survived an abort");

  AST_OP_COUNTS: assert property (@(posedge i_sys_clk)
    disable iff (!i_nrst)
    (o_op_busy && sys_r.op_cnt != 16'h0) |=>
      o_op_busy && sys_r.op_cnt == $past(sys_r.op_cnt) - 16'h1)
    else $error("internal operation stalled");

  AST_GUARD_FOLLOWS: assert property (@(posedge i_sys_clk)
    disable iff (!i_nrst)
    $changed(wp_s) |=> (o_write_guard == !$past(wp_s)))
    else $error("write guard ignored its pin");

endmodule

`default_nettype wire

// >>> rtl/sfpc_params.svh
// Constants of the serial flash pause control block.
// Included by the package users; holds defines only.
`ifndef SFPC_PARAMS_SVH
`define SFPC_PARAMS_SVH

// Time of one self-timed internal operation, and the system clock period
`define SFPC_OP_TIME_NS   200
`define SFPC_SYS_CLK_NS   50
// Longest time rounds down to whole cycles, never below one
`define SFPC_OP_CYC       ((`SFPC_OP_TIME_NS / `SFPC_SYS_CLK_NS) < 1 ? 1 : \
                           (`SFPC_OP_TIME_NS / `SFPC_SYS_CLK_NS))

// Shift geometry
`define SFPC_BYTE_W       8
`define SFPC_LAST_BIT     3'h7

// Reset values
`define SFPC_SYNC_RST     4'h7
`define SFPC_WLF_RST      1'b0
`define SFPC_SO_RST       1'b0

// Bit positions inside the synchroniser word
`define SFPC_SY_WP        0
`define SFPC_SY_HOLD      1
`define SFPC_SY_CS        2
`define SFPC_SY_TGL       3

`endif

// >>> rtl/sfpc_pkg.sv
// Types of the serial flash pause control block.
// Assumes sfpc_params.svh is on the include path.
package sfpc_pkg;

  typedef enum logic [1:0] {
    SFPC_OP_IDLE = 2'b01,
    SFPC_OP_RUN  = 2'b10
  } sfpc_op_t;

  // Link state clocked on the rising serial clock edge
  typedef struct packed {
    logic [7:0] rx_sh;
    logic [2:0] bit_cnt;
    logic [7:0] rx_byte;
    logic [7:0] tx_word;
  } sfpc_link_t;

  // Link state clocked on the falling serial clock edge
  typedef struct packed {
    logic pause_fall;
    logic so_bit;
  } sfpc_neg_t;

  // System clock state
  typedef struct packed {
    sfpc_op_t    op;
    logic [15:0] op_cnt;
    logic        wlf;
    logic        abort;
    logic        guard;
    logic        cs_n_d;
    logic        tgl_seen;
    logic [7:0]  rx_data;
    logic        rx_valid;
    logic [7:0]  tx_hold;
  } sfpc_sys_t;

endpackage

// >>> rtl/sfpc_sync.sv
// Two flip-flop level synchroniser into the system clock.
// Assumes each input bit is a level that stays put for several cycles.
`timescale 1ns/1ps
`default_nettype none

module sfpc_sync #(
  parameter int         W   = 4,
  parameter logic [3:0] RST = 4'h7
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_nrst,
  // Levels
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  if (W > 4) begin : g_chk
    $error("sfpc_sync supports at most four bits");
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_r <= RST[W-1:0];
      sync_r <= RST[W-1:0];
    end else begin
      meta_r <= i_d;
      sync_r <= meta_r;
    end
  end

  assign o_q = sync_r;

endmodule

`default_nettype wire

// >>> test/sfpc_host_model.sv
// SPI host model: drives select, clock, data and pause pins.
// Assumes mode 0: the clock idles low and stands still outside frames.
`timescale 1ns/1ps
`default_nettype none
module sfpc_host_model (
  // Pins to the device
  output logic o_sck,
  output logic o_cs_n,
  output logic o_hold_n,
  output logic o_si,
  // Pin from the device
  input  wire logic i_so
);
  initial begin
    o_sck = 1'h0;
    o_cs_n = 1'h1;
    o_hold_n = 1'h1;
    o_si = 1'h0;
  end
  // Data flips on every select change so a stale level never looks valid
  task automatic sel(input logic v);
    o_cs_n = v;
    o_si = ~o_si;
    #15;
  endtask
  task automatic bitx(input logic b);
    o_si = b;
    #15 o_sck = 1'h1;
    #15 o_sck = 1'h0;
  endtask
  // Mode 0 read: the device output is taken just before the rising edge
  task automatic bitr(input logic b, output logic r);
    o_si = b;
    #15 r = i_so;
    o_sck = 1'h1;
    #15 o_sck = 1'h0;
  endtask
  // Pause pin moves mid low phase, clear of both clock edges
  task automatic hold_lo(input logic v);
    #5 o_hold_n = v;
    #5;
  endtask
  // Misbehaving host: pause pin moved in the high phase; ends with clock high
  task automatic hi_phase(input logic v, input logic b);
    o_si = b;
    #15 o_sck = 1'h1;
    #5 o_hold_n = v;
    #10;
  endtask
  task automatic lo_phase();
    o_sck = 1'h0;
    #15;
  endtask
endmodule
`default_nettype wire

// >>> test/sfpc_pause_ctrl_tb.sv
// Testbench of the serial flash pause control block.
// Assumes the host model beside it; internal operation shortened to 3 cycles.
`timescale 1ns/1ps
`default_nettype none
module sfpc_pause_ctrl_tb;
  localparam int OPC = 3;
  logic       clk = 1'h0;
  logic       nrst = 1'h0;
  logic       wp_n = 1'h1;
  logic       wlf_set = 1'h0;
  logic       tx_load = 1'h0;
  logic [7:0] tx_data = 8'h00;
  logic       op_start = 1'h0;
  wire logic  sck, cs_n, hold_n, si;
  logic [7:0] rx_data;
  logic       so, so_oe, rx_valid, wlf, abort, guard, busy, paused;
  int         err_total = 0;
  int         n_compared = 0;
  int         cyc = 0;

  always #25 clk = ~clk;

  wire logic  so_line;

  // No pull on the output: a floating pin reads as the inverse, so an undriven read fails
  assign so_line = so_oe ? so : ~so;

  sfpc_host_model u_sfpc_host_model (.o_sck(sck), .o_cs_n(cs_n), .o_hold_n(hold_n),
    .o_si(si), .i_so(so_line));

  sfpc_pause_ctrl #(.OP_CYCLES(OPC)) u_sfpc_pause_ctrl (
    .i_sys_clk(clk), .i_nrst(nrst), .i_sck(sck), .i_cs_n(cs_n), .i_hold_n(hold_n),
    .i_si(si), .i_wp_n(wp_n), .o_so(so), .o_so_oe(so_oe), .o_rx_data(rx_data),
    .o_rx_valid(rx_valid), .i_tx_load(tx_load), .i_tx_data(tx_data),
    .i_write_latch_set(wlf_set),
    .o_write_latch_flag(wlf), .o_cmd_abort(abort), .o_write_guard(guard),
    .i_op_start(op_start), .o_op_busy(busy), .o_paused(paused));

  task automatic wrap_up();
    $display("errors %0d compared %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // A hang shows up as a run far past the fewer than 150 cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_total++;
      wrap_up();
    end
  end

  task automatic chk(input logic got, input logic exp, input string m);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s %h", $time, m, got);
    end
  endtask
  task automatic sysw(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rx_expect(input logic [7:0] d);
    logic seen;
    seen = 1'h0;
    repeat (12) begin
      sysw(1);
      if (rx_valid === 1'h1 && !seen) begin
        seen = 1'h1;
        chk8(rx_data, d, "rx byte");
      end
    end
    chk(seen, 1'h1, "no rx strobe");
  endtask

  // First byte of a frame sends zeros; the loaded word goes out in the second
  task automatic t_transmit();
    logic [7:0] tx;
    logic [7:0] d;
    logic [7:0] rx;
    logic       r;
    tx = 8'h96;
    d = 8'h5a;
    rx = 8'hc3;
    @(posedge clk);
    tx_data <= tx;
    tx_load <= 1'h1;
    @(posedge clk);
    tx_load <= 1'h0;
    u_sfpc_host_model.sel(1'h0);
    for (int i = 7; i >= 0; i--) u_sfpc_host_model.bitx(d[i]);
    rx_expect(d);
    for (int i = 7; i >= 4; i--) begin
      u_sfpc_host_model.bitr(rx[i], r);
      chk(r, tx[i], "so bit");
    end
    u_sfpc_host_model.hold_lo(1'h0);
    u_sfpc_host_model.bitx(1'h0);
    u_sfpc_host_model.bitx(1'h1);
    u_sfpc_host_model.hold_lo(1'h1);
    for (int i = 3; i >= 0; i--) begin
      u_sfpc_host_model.bitr(rx[i], r);
      chk(r, tx[i], "so bit after pause");
    end
    rx_expect(rx);
    u_sfpc_host_model.sel(1'h1);
  endtask

  task automatic t_pause_low();
    logic [7:0] d;
    d = 8'ha5;
    u_sfpc_host_model.sel(1'h0);
    for (int i = 7; i >= 4; i--) u_sfpc_host_model.bitx(d[i]);
    u_sfpc_host_model.hold_lo(1'h0);
    chk(paused, 1'h1, "not paused");
    chk(so_oe, 1'h0, "so driven");
    for (int i = 0; i < 4; i++) u_sfpc_host_model.bitx(i[0]);
    chk(paused, 1'h1, "pause lost");
    u_sfpc_host_model.hold_lo(1'h1);
    chk(paused, 1'h0, "pause stuck");
    for (int i = 3; i >= 0; i--) u_sfpc_host_model.bitx(d[i]);
    rx_expect(d);
    u_sfpc_host_model.sel(1'h1);
  endtask

  task automatic t_pause_high();
    logic [7:0] d;
    logic [7:0] n;
    d = 8'h3c;
    n = 8'h00;
    u_sfpc_host_model.sel(1'h0);
    for (int i = 7; i >= 5; i--) u_sfpc_host_model.bitx(d[i]);
    u_sfpc_host_model.hi_phase(1'h0, d[4]);
    chk(paused, 1'h0, "early pause");
    u_sfpc_host_model.lo_phase();
    chk(paused, 1'h1, "late pause");
    @(posedge clk) wp_n <= 1'h0;
    sysw(4);
    chk(guard, 1'h1, "guard on");
    @(posedge clk) wp_n <= 1'h1;
    sysw(4);
    chk(guard, 1'h0, "guard off");
    @(posedge clk) op_start <= 1'h1;
    @(posedge clk) op_start <= 1'h0;
    repeat (12) begin
      #1;
      if (busy === 1'h1) n++;
      @(posedge clk);
    end
    chk8(n, 8'(OPC), "busy length");
    u_sfpc_host_model.bitx(1'h1);
    u_sfpc_host_model.bitx(1'h0);
    u_sfpc_host_model.hi_phase(1'h1, 1'h1);
    chk(paused, 1'h1, "early resume");
    u_sfpc_host_model.lo_phase();
    chk(paused, 1'h0, "late resume");
    for (int i = 3; i >= 0; i--) u_sfpc_host_model.bitx(d[i]);
    rx_expect(d);
    u_sfpc_host_model.sel(1'h1);
  endtask

  task automatic t_unselected();
    u_sfpc_host_model.hold_lo(1'h0);
    sysw(3);
    chk(paused, 1'h0, "paused unselected");
    u_sfpc_host_model.hold_lo(1'h1);
  endtask

  task automatic t_abort();
    logic seen;
    seen = 1'h0;
    @(posedge clk) wlf_set <= 1'h1;
    @(posedge clk) wlf_set <= 1'h0;
    sysw(1);
    chk(wlf, 1'h1, "flag not set");
    u_sfpc_host_model.sel(1'h0);
    u_sfpc_host_model.bitx(1'h1);
    u_sfpc_host_model.hold_lo(1'h0);
    u_sfpc_host_model.sel(1'h1);
    repeat (10) begin
      sysw(1);
      if (abort === 1'h1) seen = 1'h1;
    end
    chk(seen, 1'h1, "no abort");
    chk(wlf, 1'h0, "flag kept");
    u_sfpc_host_model.hold_lo(1'h1);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'h1;
    sysw(4);
    t_transmit();
    t_pause_low();
    t_pause_high();
    t_unselected();
    t_abort();
    wrap_up();
  end
endmodule
`default_nettype wire
